// [hlbr_defs.vh]
// Constants for the host link break, reset and framing block.
`ifndef HLBR_DEFS_VH
`define HLBR_DEFS_VH
// APB register byte offsets.
`define HLBR_REG_LINK_CONTROL 12'h000
`define HLBR_REG_MAIN_CONTROL 12'h004
`define HLBR_REG_RX_FAULT 12'h008
`define HLBR_REG_TR_FAULT 12'h00c
`define HLBR_REG_FRAME_TIMEOUT 12'h010
`define HLBR_REG_STATUS 12'h014
// Link control fields.
`define HLBR_LC_BAUD_LSB 0
`define HLBR_LC_TXEN_BIT 2
`define HLBR_LC_TOEN_BIT 3
`define HLBR_LC_RESET 32'h0000000f
// Main control fields.
`define HLBR_MC_SHARED_BIT 0
`define HLBR_MC_STACK_BIT 1
`define HLBR_MC_DIR_BIT 2
`define HLBR_MC_ACTIVE_BIT 3
`define HLBR_MC_RESET 32'h00000008
// Receive fault flag positions.
`define HLBR_RXF_CLEAR 0
`define HLBR_RXF_RESET 1
`define HLBR_RXF_STOP 2
// Transaction fault flag positions.
`define HLBR_TRF_WAIT 0
`define HLBR_TRF_SOF 1
`define HLBR_TRF_TIMEOUT 2
// Baud codes.
`define HLBR_BAUD_250K 2'b01
// Break and reset durations in bit periods.
`define HLBR_BRK_MIN_BITS 16'h000f
`define HLBR_RST_BITS 16'h0800
// Clock period in ns and frame timeout default in us.
`define HLBR_CLK_NS 4
`define HLBR_FTO_US 1000
// Request types.
`define HLBR_REQ_SREAD 3'b000
`define HLBR_REQ_SWRITE 3'b001
`define HLBR_REQ_KREAD 3'b010
`define HLBR_REQ_KWRITE 3'b011
`define HLBR_REQ_BREAD 3'b100
`define HLBR_REQ_BWRITE 3'b101
`define HLBR_REQ_BREV 3'b110
`endif

// [hlbr_sync.v]
// Two flip-flop synchroniser for the receive pin.
`timescale 1ns/1ps
module hlbr_sync (
  input wire pclk,
  input wire presetn,
  input wire din,
  output wire dout
);
  reg meta_ff;
  reg sync_ff;

  // Idle line is high, so both stages reset high.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;
endmodule

// [hlbr_low_timer.v]
// Low-level duration counter measured in bit periods.
`timescale 1ns/1ps
module hlbr_low_timer (
  input wire pclk,
  input wire presetn,
  input wire rx_level,
  input wire bit_tick,
  output wire [15:0] low_bits
);
  reg [15:0] cnt_ff;

  // Counts whole bit periods while low; saturates so a stuck line never wraps.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 16'h0000;
    end else if (rx_level) begin
      cnt_ff <= 16'h0000;
    end else if (bit_tick && cnt_ff != 16'hffff) begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end

  assign low_bits = cnt_ff;
endmodule

// [hlbr_top.v]
// Host link break/reset detection and command framing control.
//
// Functional notes
// - Watch receive line always; long low for minimum break bits is a clear.
// - After a clear, flush state; next byte starts a new frame; a chain-mode send here stays in ST_SEND instead.
// - A clear sets clear-detected flag, and framing error flag only when active.
// - Chain mode clear while awaiting read drops response, sets wait or start flag.
// - Shared-bus clear discards pending or stops sending response; sets wait flag.
// - Wake on sleeping device sets only clear flag; active also sets framing.
// - Reset-length low forces 250 kbps, sets reset flag, keeps stored baud.
// - Communication reset acts on this base device only.
// - Low beyond reset duration also emits wake tones and performs a clear.
// - Reset while awaiting broadcast or stack read drops response, sets wait flag.
// - A communication reset also sets the framing error flag.
// - Never transmit unprompted; only answer a received command frame.
// - Stack read and write act only when stack member select is 1.
// - Broadcast read and write are accepted by every device.
// - Reverse broadcast write goes opposite to the direction select.
// - Only read commands produce a response frame.
// - Init byte marks command or response and gives following byte count.
// - Missing bytes before frame timeout raise timeout fault when enabled.
// - Init bit 7 is 1 for command, 0 for response.
// - Request type codes 000 to 101, with 110 reverse broadcast write.
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "hlbr_defs.vh"
module hlbr_top #(
  parameter [31:0] FTO_CYCLES = (`HLBR_FTO_US * 1000) / `HLBR_CLK_NS
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire rx_pin,
  input wire bit_tick,
  input wire rx_byte_valid,
  input wire [7:0] rx_byte,
  input wire rx_stop_error,
  input wire tx_busy,
  output reg resp_start_ff,
  output reg [6:0] resp_len_ff,
  output reg resp_abort_ff,
  output reg rx_flush_ff,
  output reg wake_tone_ff,
  output reg fwd_reverse_ff,
  output reg [1:0] active_baud_ff,
  output reg cmd_write_ff,
  output wire sleep_wake_ff_unused
);
  // -----------------------------------------------------------------
  // Frame states
  // -----------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_BODY = 3'd1;
  localparam [2:0] ST_WAIT = 3'd2;
  localparam [2:0] ST_SEND = 3'd3;

  // Control, fault and frame bookkeeping registers.
  reg [31:0] link_control_ff;
  reg [31:0] main_control_ff;
  reg [2:0] rx_fault_ff;
  reg [2:0] tr_fault_ff;
  reg [2:0] state_ff;
  reg [4:0] bytes_left_ff;
  reg [2:0] req_ff;
  reg [6:0] size_ff;
  reg [31:0] fto_cnt_ff;
  reg brk_seen_ff;
  reg rst_seen_ff;
  reg rst_mode_ff;
  reg first_byte_ff;
  // Synchronised receive level and its low-time count.
  wire rx_s;
  wire [15:0] low_bits;

  // Spare output held low; sleep handling lives outside this block.
  assign sleep_wake_ff_unused = 1'b0;

  // -----------------------------------------------------------------
  // Pin synchroniser and low timer
  // -----------------------------------------------------------------
  hlbr_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(rx_pin),
    .dout(rx_s)
  );

  hlbr_low_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .rx_level(rx_s),
    .bit_tick(bit_tick),
    .low_bits(low_bits)
  );

  // Decode helpers used by the frame logic.
  function is_read;
    input [2:0] r;
    begin
      is_read = (r == `HLBR_REQ_SREAD) || (r == `HLBR_REQ_KREAD) || (r == `HLBR_REQ_BREAD);
    end
  endfunction

  function accepted;
    input [2:0] r;
    input stack_member;
    begin
      case (r)
        `HLBR_REQ_KREAD, `HLBR_REQ_KWRITE: accepted = stack_member;
        `HLBR_REQ_BREAD, `HLBR_REQ_BWRITE, `HLBR_REQ_BREV: accepted = 1'b1;
        default: accepted = 1'b1;
      endcase
    end
  endfunction

  // -----------------------------------------------------------------
  // Break and reset events
  // -----------------------------------------------------------------
  // Events fire once per low period, on the count crossing each threshold.
  wire clear_evt = !rx_s && bit_tick && (low_bits == `HLBR_BRK_MIN_BITS - 16'h0001);
  wire reset_evt = !rx_s && bit_tick && (low_bits == `HLBR_RST_BITS - 16'h0001);
  wire active = main_control_ff[`HLBR_MC_ACTIVE_BIT];
  wire shared = main_control_ff[`HLBR_MC_SHARED_BIT];
  wire pending = (state_ff == ST_WAIT);
  wire sending = (state_ff == ST_SEND);

  // APB bus: zero wait state, all decodes answered, unmapped read as zero.
  wire wr = psel && penable && pwrite;
  wire rd = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // Write-one-to-clear masks for the fault registers.
  wire [2:0] rxf_clr = (wr && paddr == `HLBR_REG_RX_FAULT) ? pwdata[2:0] : 3'b000;
  wire [2:0] trf_clr = (wr && paddr == `HLBR_REG_TR_FAULT) ? pwdata[2:0] : 3'b000;

  // Timeout fires when a frame body is still open at the limit, counted from its init byte.
  wire fto_evt = (state_ff == ST_BODY) && (fto_cnt_ff == FTO_CYCLES - 32'd1)
                 && link_control_ff[`HLBR_LC_TOEN_BIT];

  // -----------------------------------------------------------------
  // Init byte decode
  // -----------------------------------------------------------------
  // Fields of a received init byte; only meaningful while rx_byte_valid is high.
  wire init_is_cmd = rx_byte[7];
  wire [2:0] init_req = rx_byte[6:4];
  wire [2:0] init_size = rx_byte[2:0];
  // Single-device requests carry a device address byte; the others omit it.
  wire init_has_addr = (init_req == `HLBR_REQ_SREAD) || (init_req == `HLBR_REQ_SWRITE);
  // Bytes after the init byte: size plus one data bytes, two address bytes, two check bytes.
  wire [4:0] init_body = {2'b00, init_size} + 5'd5 + {4'h0, init_has_addr};

  // -----------------------------------------------------------------
  // Fault flag set terms
  // -----------------------------------------------------------------
  // A held-low line reads as a zero stop bit, except when it wakes a sleeping device.
  wire stop_set = (clear_evt && active) || reset_evt || (rx_byte_valid && rx_stop_error);
  // Chain mode: a clear on the first waiting cycle loses the response start.
  wire sof_set = clear_evt && !shared && pending && first_byte_ff;
  // Later in chain mode, or at any time on a shared bus, it is a plain wait drop.
  wire drop_now = shared ? (pending || sending) : (pending && !first_byte_ff);
  wire wait_set = (clear_evt && drop_now) || (reset_evt && pending && req_ff != `HLBR_REQ_SREAD);
  // Set terms are ORed after the clear mask, so an event beats a same-cycle clear.
  wire [2:0] nxt_rx_fault = (rx_fault_ff & ~rxf_clr) | {stop_set, reset_evt, clear_evt};
  wire [2:0] nxt_tr_fault = (tr_fault_ff & ~trf_clr) | {fto_evt, sof_set, wait_set};

  // -----------------------------------------------------------------
  // Control registers
  // -----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_control_ff <= `HLBR_LC_RESET;
      main_control_ff <= `HLBR_MC_RESET;
    end else if (wr && paddr == `HLBR_REG_LINK_CONTROL) begin
      link_control_ff <= {28'h0000000, pwdata[3:0]};
    end else if (wr && paddr == `HLBR_REG_MAIN_CONTROL) begin
      main_control_ff <= {28'h0000000, pwdata[3:0]};
    end else if (clear_evt && !active) begin
      // A wake leaves the device active afterwards.
      main_control_ff[`HLBR_MC_ACTIVE_BIT] <= 1'b1;
    end
  end

  // Sticky fault flags; a hardware set beats a same-cycle software clear.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_fault_ff <= 3'b000;
      tr_fault_ff <= 3'b000;
    end else begin
      rx_fault_ff <= nxt_rx_fault;
      tr_fault_ff <= nxt_tr_fault;
    end
  end

  // Active baud: forced to 250 kbps on reset, stored field untouched.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_baud_ff <= `HLBR_BAUD_250K;
      rst_mode_ff <= 1'b0;
    end else if (reset_evt) begin
      active_baud_ff <= `HLBR_BAUD_250K;
      rst_mode_ff <= 1'b1;
    end else if (wr && paddr == `HLBR_REG_LINK_CONTROL) begin
      active_baud_ff <= pwdata[1:0];
      rst_mode_ff <= 1'b0;
    end else if (!rst_mode_ff) begin
      active_baud_ff <= link_control_ff[1:0];
    end
  end

  // Low-period latches remember each event for the rest of its held-low period.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_seen_ff <= 1'b0;
      rst_seen_ff <= 1'b0;
      wake_tone_ff <= 1'b0;
    end else begin
      brk_seen_ff <= rx_s ? 1'b0 : (brk_seen_ff | clear_evt);
      rst_seen_ff <= rx_s ? 1'b0 : (rst_seen_ff | reset_evt);
      // Tones stay on while the line stays held past the reset length.
      wake_tone_ff <= !rx_s && (rst_seen_ff || reset_evt);
    end
  end

  // -----------------------------------------------------------------
  // Frame state machine
  // -----------------------------------------------------------------
  // Bytes arriving while we transmit are ignored; only a break on a shared bus breaks in.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_IDLE;
      bytes_left_ff <= 5'd0;
      req_ff <= 3'b000;
      size_ff <= 7'd0;
      fto_cnt_ff <= 32'd0;
      first_byte_ff <= 1'b0;
      resp_start_ff <= 1'b0;
      resp_len_ff <= 7'd0;
      resp_abort_ff <= 1'b0;
      rx_flush_ff <= 1'b0;
      fwd_reverse_ff <= 1'b0;
      cmd_write_ff <= 1'b0;
    end else begin
      resp_start_ff <= 1'b0;
      resp_abort_ff <= 1'b0;
      rx_flush_ff <= 1'b0;
      cmd_write_ff <= 1'b0;
      // Counts only while a body is open; any other state parks it at zero.
      fto_cnt_ff <= (state_ff == ST_BODY) ? fto_cnt_ff + 32'd1 : 32'd0;
      if (clear_evt || reset_evt) begin
        // Flush; next byte is a start of frame unless a chain-mode response is still sending. A reset includes a clear.
        rx_flush_ff <= 1'b1;
        resp_abort_ff <= pending || (sending && shared);
        if (!(sending && !shared)) begin
          state_ff <= ST_IDLE;
        end
      end else begin
        case (state_ff)
          ST_IDLE: begin
            // Only command-type init bytes open a frame.
            if (rx_byte_valid && init_is_cmd) begin
              req_ff <= init_req;
              size_ff <= {4'h0, init_size} + 7'd1;
              bytes_left_ff <= init_body;
              first_byte_ff <= 1'b1;
              state_ff <= ST_BODY;
            end
          end
          ST_BODY: begin
            // A stalled body is abandoned so that the next init byte is heard.
            if (fto_evt) begin
              state_ff <= ST_IDLE;
            end else if (rx_byte_valid) begin
              bytes_left_ff <= bytes_left_ff - 5'd1;
              // The last body byte decides whether this device takes the request.
              if (bytes_left_ff == 5'd1) begin
                if (!accepted(req_ff, main_control_ff[`HLBR_MC_STACK_BIT])) begin
                  state_ff <= ST_IDLE;
                end else if (is_read(req_ff)) begin
                  state_ff <= ST_WAIT;
                  first_byte_ff <= 1'b1;
                end else begin
                  cmd_write_ff <= 1'b1;
                  fwd_reverse_ff <= (req_ff == `HLBR_REQ_BREV)
                    ? !main_control_ff[`HLBR_MC_DIR_BIT] : main_control_ff[`HLBR_MC_DIR_BIT];
                  state_ff <= ST_IDLE;
                end
              end
            end
          end
          ST_WAIT: begin
            // Transmit only in answer to a received read command.
            if (link_control_ff[`HLBR_LC_TXEN_BIT]) begin
              resp_start_ff <= 1'b1;
              resp_len_ff <= size_ff - 7'd1;
              state_ff <= ST_SEND;
            end else begin
              // With the transmitter off the response waits here until a clear drops it.
              first_byte_ff <= 1'b0;
            end
          end
          ST_SEND: begin
            if (!tx_busy && !resp_start_ff) begin
              state_ff <= ST_IDLE;
            end
          end
          default: state_ff <= ST_IDLE;
        endcase
      end
    end
  end

  // -----------------------------------------------------------------
  // Read data
  // -----------------------------------------------------------------
  // Loaded in the setup cycle so that it stands through the access phase.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd) begin
      case (paddr)
        `HLBR_REG_LINK_CONTROL: prdata <= link_control_ff;
        `HLBR_REG_MAIN_CONTROL: prdata <= main_control_ff;
        `HLBR_REG_RX_FAULT: prdata <= {29'h0, rx_fault_ff};
        `HLBR_REG_TR_FAULT: prdata <= {29'h0, tr_fault_ff};
        `HLBR_REG_FRAME_TIMEOUT: prdata <= FTO_CYCLES;
        `HLBR_REG_STATUS: prdata <= {27'h0, active_baud_ff, state_ff};
        default: prdata <= 32'h00000000;
      endcase
    end
  end
endmodule

// [hlbr_chk.sv]
// Port-level checker for the host link break, reset and framing block.
`timescale 1ns/1ps
module hlbr_chk (
  input wire pclk,
  input wire presetn,
  input wire rx_pin,
  input wire rx_byte_valid,
  input wire resp_start_ff,
  input wire resp_abort_ff,
  input wire rx_flush_ff,
  input wire wake_tone_ff,
  input wire [1:0] active_baud_ff,
  input wire cmd_write_ff
);
  reg got_ff;
  reg nxt_got;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ----
  // Helper logic
  // ----
  // A response is owed only once a byte has come in since the last response.
  always @* nxt_got = rx_byte_valid ? 1'b1 : (resp_start_ff ? 1'b0 : got_ff);
  // The flag register follows its next value.
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      got_ff <= 1'b0;
    else
      got_ff <= nxt_got;
  sequence s_tone_on;
    $rose(wake_tone_ff);
  endsequence
  // ----
  // Assertions
  // ----
  flush_pulse_a: assert property (rx_flush_ff |=> !rx_flush_ff)
    else $error("flush longer than one cycle");
  flush_low_a: assert property (rx_flush_ff |-> $past(rx_pin, 4) == 1'b0)
    else $error("flush without low line");
  abort_pulse_a: assert property (resp_abort_ff |=> !resp_abort_ff)
    else $error("abort longer than one cycle");
  abort_low_a: assert property (resp_abort_ff |-> $past(rx_pin, 4) == 1'b0)
    else $error("abort without low line");
  prompted_tx_a: assert property (resp_start_ff |-> got_ff)
    else $error("response without received byte");
  write_quiet_a: assert property (cmd_write_ff |-> (!resp_start_ff) [*8])
    else $error("response after write");
  tone_low_a: assert property (s_tone_on |-> $past(rx_pin, 3) == 1'b0)
    else $error("wake tone with line high");
  reset_baud_a: assert property (s_tone_on |-> ##[0:8] active_baud_ff == 2'b01)
    else $error("rate not forced after reset");
endmodule
bind hlbr_top hlbr_chk u_chk (.pclk, .presetn, .rx_pin, .rx_byte_valid, .resp_start_ff, .resp_abort_ff,
  .rx_flush_ff, .wake_tone_ff, .active_baud_ff, .cmd_write_ff);

// [hlbr_host_model.sv]
// Host-side model of the serial link: bit strobes, low levels and received bytes.
`timescale 1ns/1ps
module hlbr_host_model #(
  parameter int TICK_DIV = 2,
  parameter int RECOVER_BITS = 4
) (
  input wire pclk,
  output logic rx_pin,
  output logic bit_tick,
  output logic rx_byte_valid,
  output logic [7:0] rx_byte,
  output logic rx_stop_error
);
  int div = 0;
  // Line idles high; byte data is inverted when not valid so stale values never match.
  initial begin
    rx_pin = 1'b1;
    rx_byte_valid = 1'b0;
    rx_byte = 8'h5a;
    rx_stop_error = 1'b0;
  end
  // Free-running bit period strobe, one clock wide.
  always @(posedge pclk) begin
    div <= (div == TICK_DIV - 1) ? 0 : div + 1;
    bit_tick <= (div == TICK_DIV - 1);
  end
  // Low level for some bit periods, then a quiet gap before any byte.
  task automatic hold_low(input int bits);
    @(posedge pclk);
    rx_pin <= 1'b0;
    repeat (bits * TICK_DIV) @(posedge pclk);
    rx_pin <= 1'b1;
    repeat (RECOVER_BITS * TICK_DIV) @(posedge pclk);
  endtask
  // One received byte, flagged for a single cycle.
  task automatic send_byte(input logic [7:0] b);
    @(posedge pclk);
    rx_byte_valid <= 1'b1;
    rx_byte <= b;
    @(posedge pclk);
    rx_byte_valid <= 1'b0;
    rx_byte <= ~b;
    repeat (3) @(posedge pclk);
  endtask
  // The same byte, reported with its stop bit seen low.
  task automatic send_bad_byte(input logic [7:0] b);
    rx_stop_error <= 1'b1;
    send_byte(b);
    rx_stop_error <= 1'b0;
  endtask
endmodule

// [tb_top.sv]
// Self-checking bench for the host link break, reset and framing block.
`timescale 1ns/1ps
`include "hlbr_defs.vh"
module tb_top;
  localparam int FTO = 64;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic tx_busy = 1'b0;
  logic [31:0] q;
  wire [31:0] prdata;
  wire pready, pslverr, sleep_wake_ff_unused, rx_pin, bit_tick, rx_byte_valid, rx_stop_error;
  wire [7:0] rx_byte;
  wire resp_start_ff, resp_abort_ff, rx_flush_ff, wake_tone_ff, fwd_reverse_ff, cmd_write_ff;
  wire [6:0] resp_len_ff;
  wire [1:0] active_baud_ff;
  int n_mismatch = 0;
  int total_checks = 0;
  int n_wr = 0, n_rs = 0, n_ab = 0, n_fl = 0, n_wk = 0, s, p, t;
  always #2 pclk = ~pclk;
  hlbr_top #(.FTO_CYCLES(FTO)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rx_pin, .bit_tick, .rx_byte_valid, .rx_byte, .rx_stop_error, .tx_busy,
    .resp_start_ff, .resp_len_ff, .resp_abort_ff, .rx_flush_ff, .wake_tone_ff, .fwd_reverse_ff,
    .active_baud_ff, .cmd_write_ff, .sleep_wake_ff_unused);
  hlbr_host_model u_host (.pclk, .rx_pin, .bit_tick, .rx_byte_valid, .rx_byte, .rx_stop_error);
  // Pulse counters sample settled values at each edge.
  always @(posedge pclk) begin
    n_wr += (cmd_write_ff === 1'b1);
    n_rs += (resp_start_ff === 1'b1);
    n_ab += (resp_abort_ff === 1'b1);
    n_fl += (rx_flush_ff === 1'b1);
    n_wk += (wake_tone_ff === 1'b1);
  end
  // ----
  // Tasks
  // ----
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_mismatch++;
      complete_run();
    end
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(nm, q, e);
  endtask
  // Sends a command, then fillers until the block reacts; the limit guards a hang.
  task automatic frame(input logic [7:0] init);
    int c;
    c = n_wr + n_rs;
    u_host.send_byte(init);
    for (int i = 0; i < 12 && n_wr + n_rs == c; i++)
      u_host.send_byte(8'h00);
    repeat (20) @(posedge pclk);
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd("link_control", `HLBR_REG_LINK_CONTROL, `HLBR_LC_RESET);
    rd("main_control", `HLBR_REG_MAIN_CONTROL, `HLBR_MC_RESET);
    rd("rx_faults", `HLBR_REG_RX_FAULT, 32'h0);
    apb(1'b1, `HLBR_REG_FRAME_TIMEOUT, 32'h5);
    rd("timeout", `HLBR_REG_FRAME_TIMEOUT, FTO);
    apb(1'b1, 12'h100, 32'hff);
    rd("unmapped", 12'h100, 32'h0);
    check("pslverr", pslverr, 1'b0);
    check("spare", sleep_wake_ff_unused, 1'b0);
    // A byte with a low stop bit raises the framing flag, which holds until cleared.
    u_host.send_bad_byte(8'h00);
    rd("rx_faults", `HLBR_REG_RX_FAULT, 32'h4);
    apb(1'b1, `HLBR_REG_RX_FAULT, 32'h4);
    $display("test registers done");
    // A sleeping block records only the clear; an active one also the stop bit.
    for (int a = 1; a >= 0; a--) begin
      apb(1'b1, `HLBR_REG_MAIN_CONTROL, a << `HLBR_MC_ACTIVE_BIT);
      s = n_fl;
      u_host.hold_low(20);
      check("flush", n_fl - s, 1);
      rd("rx_faults", `HLBR_REG_RX_FAULT, a ? 32'h5 : 32'h1);
      rd("rx_faults", `HLBR_REG_RX_FAULT, a ? 32'h5 : 32'h1);
      apb(1'b1, `HLBR_REG_RX_FAULT, 32'h7);
      rd("rx_faults", `HLBR_REG_RX_FAULT, 32'h0);
    end
    $display("test clear done");
    // Every request type, with and without stack membership.
    for (int st = 0; st < 2; st++) begin
      apb(1'b1, `HLBR_REG_MAIN_CONTROL, 32'h8 | (st << `HLBR_MC_STACK_BIT));
      for (int r = 0; r < 7; r++) begin
        s = n_wr;
        p = n_rs;
        frame({1'b1, r[2:0], 4'h3});
        check("writes", n_wr - s, r == 1 || r == 5 || r == 6 || (r == 3 && st == 1));
        check("reads", n_rs - p, r == 0 || r == 4 || (r == 2 && st == 1));
        if (r >= 5)
          check("reverse", fwd_reverse_ff, r == 6);
        if (n_rs != p)
          check("resp_len", resp_len_ff, 7'h3);
        u_host.hold_low(20);
      end
    end
    $display("test requests done");
    // A frame cut short trips the timeout only when it is enabled.
    for (int en = 1; en >= 0; en--) begin
      apb(1'b1, `HLBR_REG_LINK_CONTROL, 32'h7 | (en << `HLBR_LC_TOEN_BIT));
      apb(1'b1, `HLBR_REG_TR_FAULT, 32'h7);
      u_host.send_byte({1'b1, `HLBR_REQ_BWRITE, 4'h3});
      repeat (FTO + 40) @(posedge pclk);
      rd("tr_faults", `HLBR_REG_TR_FAULT, en << `HLBR_TRF_TIMEOUT);
      u_host.hold_low(20);
    end
    $display("test timeout done");
    // Shared bus: a clear during a response stops it.
    apb(1'b1, `HLBR_REG_MAIN_CONTROL, 32'h9);
    u_host.hold_low(20);
    apb(1'b1, `HLBR_REG_TR_FAULT, 32'h7);
    tx_busy <= 1'b1;
    frame({1'b1, `HLBR_REQ_BREAD, 4'h3});
    s = n_ab;
    u_host.hold_low(20);
    check("abort", n_ab - s, 1);
    rd("tr_faults", `HLBR_REG_TR_FAULT, 32'h1);
    tx_busy <= 1'b0;
    $display("test shared done");
    // Reset-length low forces the fallback rate but keeps the stored setting.
    // A broadcast read is left waiting with the transmitter off, so the clear at break length drops it.
    apb(1'b1, `HLBR_REG_MAIN_CONTROL, 32'h8);
    apb(1'b1, `HLBR_REG_LINK_CONTROL, 32'h8);
    apb(1'b1, `HLBR_REG_RX_FAULT, 32'h7);
    apb(1'b1, `HLBR_REG_TR_FAULT, 32'h7);
    p = n_rs;
    frame({1'b1, `HLBR_REQ_BREAD, 4'h3});
    check("silent", n_rs - p, 0);
    s = n_fl;
    p = n_wk;
    t = n_ab;
    u_host.hold_low(`HLBR_RST_BITS + 52);
    rd("rx_faults", `HLBR_REG_RX_FAULT, 32'h7);
    rd("tr_faults", `HLBR_REG_TR_FAULT, 32'h1);
    check("abort", n_ab - t, 1);
    check("baud", active_baud_ff, `HLBR_BAUD_250K);
    rd("link_control", `HLBR_REG_LINK_CONTROL, 32'h8);
    check("tone", n_wk > p, 1);
    check("flush", n_fl > s, 1);
    $display("test reset done");
    complete_run();
  end
endmodule
